// File: src/dcs_word_core.sv
// drive command word decoder and condition word assembler
// Behaviour
// - bits 1:0 pick one of four presets
// - bit 2 low applies dc brake stop
// - bit 3 low coasts, output stage off
// - bit 4 low requests quick stop ramp
// - bit 5 low freezes output frequency
// - frozen: only coast or brake stops
// - bit 6 low ramps down, high allows start
// - trip reset on rising edge of bit 7
// - bit 8 high selects jog speed
// - bit 9 selects ramp pair two
// - bit 10 low ignores whole command word
// - bit 11 drives relay one if configured
// - bit 12 drives relay two if configured
// - bit 13 picks set-up in multi mode
// - bit 15 reverses if source allows serial
// - status bits 0..2 ready, ready, enable
// - status bit 5 always zero
// - status bits 3,4,6,7 report faults separately
// - status bit 8 shows speed at reference
// - status bit 9 shows bus control possible
// - status bits 10,11 limits and running
// - status bits 12..15 temperature, voltage, torque, timer
`timescale 1ns/1ps
module dcs_word_core
  import dcs_pkg::*;
(
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  // command word from the bus transport
  input  wire logic [15:0]  i_command_word,
  input  wire logic         i_command_strobe,
  // drive settings
  input  wire logic [5:0]   i_relay1_function,
  input  wire logic [5:0]   i_relay2_function,
  input  wire logic [3:0]   i_active_setup,
  input  wire logic [1:0]   i_reverse_source,
  // digital input pins (asynchronous)
  input  wire logic         i_din_reverse,
  input  wire logic         i_din_coast,
  input  wire logic         i_din_dc_brake,
  input  wire logic         i_din_speed_up,
  input  wire logic         i_din_slow_down,
  // drive state from motor control
  input  wire logic         i_controls_ready,
  input  wire logic         i_drive_ready,
  input  wire logic         i_tripped,
  input  wire logic         i_error,
  input  wire logic         i_trip_locked,
  input  wire logic         i_warning,
  input  wire logic         i_at_reference,
  input  wire logic         i_panel_off,
  input  wire logic         i_site_local,
  input  wire logic         i_freq_in_limits,
  input  wire logic         i_start_present,
  input  wire logic         i_freq_nonzero,
  input  wire logic         i_overtemp_pause,
  input  wire logic         i_dc_voltage_bad,
  input  wire logic         i_current_limit,
  input  wire logic         i_thermal_timer_over,
  // decoded commands to motor control
  output logic [1:0]        o_preset_select,
  output logic              o_dc_brake,
  output logic              o_coast,
  output logic              o_quick_stop,
  output logic              o_freeze,
  output logic              o_speed_up,
  output logic              o_slow_down,
  output logic              o_ramp_stop,
  output logic              o_start_enable,
  output logic              o_trip_reset,
  output logic              o_jog,
  output logic              o_ramp_pair2,
  output logic              o_relay1,
  output logic              o_relay2,
  output logic              o_setup2,
  output logic              o_reverse,
  // condition word back to the master
  output logic [15:0]       o_drive_condition_word
);
  logic [15:0] drive_command_word_reg;
  logic        reset_bit_prev_reg;
  logic [1:0]  preset_reg;
  logic        dc_brake_reg;
  logic        coast_reg;
  logic        quick_stop_reg;
  logic        freeze_reg;
  logic        speed_up_reg;
  logic        slow_down_reg;
  logic        ramp_stop_reg;
  logic        start_enable_reg;
  logic        trip_reset_reg;
  logic        jog_reg;
  logic        ramp_pair2_reg;
  logic        relay1_reg;
  logic        relay2_reg;
  logic        setup2_reg;
  logic        reverse_reg;
  logic [15:0] condition_reg;
  logic [15:0] condition_next;
  logic [4:0]  din_level;
  logic        din_reverse;
  logic        din_coast;
  logic        din_dc_brake;
  logic        din_speed_up;
  logic        din_slow_down;
  logic        bus_reverse;
  logic        rev_next;

  // test a command bit of the held word
  function automatic logic cmd_bit(input logic [15:0] word, input int pos);
    cmd_bit = word[pos];
  endfunction

  // digital input synchronisers
  dcs_sync #(
    .WIDTH (5)
  ) u_din_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async ({i_din_slow_down, i_din_speed_up, i_din_dc_brake, i_din_coast, i_din_reverse}),
    .o_level (din_level)
  );

  assign din_reverse   = din_level[0];
  assign din_coast     = din_level[1];
  assign din_dc_brake  = din_level[2];
  assign din_speed_up  = din_level[3];
  assign din_slow_down = din_level[4];

  // latch command word only when marked valid
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      drive_command_word_reg <= CMD_RESET_VALUE;
    else if (i_command_strobe && i_command_word[CMD_VALID])
      drive_command_word_reg <= i_command_word;
  end

  // trip reset pulse on rising edge of the reset bit
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      reset_bit_prev_reg <= 1'b0;
      trip_reset_reg     <= 1'b0;
    end
    else
    begin
      reset_bit_prev_reg <= cmd_bit(drive_command_word_reg, CMD_RESET);
      trip_reset_reg     <= cmd_bit(drive_command_word_reg, CMD_RESET) && !reset_bit_prev_reg;
    end
  end

  // preset, ramp pair and jog selection
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      preset_reg     <= 2'h0;
      ramp_pair2_reg <= 1'b0;
      jog_reg        <= 1'b0;
    end
    else
    begin
      preset_reg     <= {cmd_bit(drive_command_word_reg, CMD_REF_MSB),
                         cmd_bit(drive_command_word_reg, CMD_REF_LSB)};
      ramp_pair2_reg <= cmd_bit(drive_command_word_reg, CMD_RAMP_SEL);
      jog_reg        <= cmd_bit(drive_command_word_reg, CMD_JOG);
    end
  end

  // stop commands; freeze masks the ramp-type stops
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      dc_brake_reg     <= 1'b0;
      coast_reg        <= 1'b1;
      quick_stop_reg   <= 1'b0;
      freeze_reg       <= 1'b0;
      ramp_stop_reg    <= 1'b1;
      start_enable_reg <= 1'b0;
    end
    else
    begin
      freeze_reg     <= !cmd_bit(drive_command_word_reg, CMD_HOLD_N);
      dc_brake_reg   <= !cmd_bit(drive_command_word_reg, CMD_DC_BRAKE_N) || din_dc_brake;
      coast_reg      <= !cmd_bit(drive_command_word_reg, CMD_COAST_N) || din_coast;
      quick_stop_reg <= !cmd_bit(drive_command_word_reg, CMD_QSTOP_N)
                        && cmd_bit(drive_command_word_reg, CMD_HOLD_N);
      ramp_stop_reg  <= !cmd_bit(drive_command_word_reg, CMD_RAMP_START)
                        && cmd_bit(drive_command_word_reg, CMD_HOLD_N);
      start_enable_reg <= cmd_bit(drive_command_word_reg, CMD_RAMP_START)
                          && cmd_bit(drive_command_word_reg, CMD_COAST_N) && !din_coast;
    end
  end

  // speed up/down inputs only act on a frozen frequency
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      speed_up_reg  <= 1'b0;
      slow_down_reg <= 1'b0;
    end
    else
    begin
      speed_up_reg  <= !cmd_bit(drive_command_word_reg, CMD_HOLD_N) && din_speed_up;
      slow_down_reg <= !cmd_bit(drive_command_word_reg, CMD_HOLD_N) && din_slow_down;
    end
  end

  // relays, set-up and reversing, each gated by its setting
  assign bus_reverse = cmd_bit(drive_command_word_reg, CMD_REVERSE);

  always_comb
  begin
    unique case (dcs_rev_src_t'(i_reverse_source))
      DCS_REV_SERIAL: rev_next = bus_reverse;
      DCS_REV_OR:     rev_next = bus_reverse || din_reverse;
      DCS_REV_AND:    rev_next = bus_reverse && din_reverse;
      DCS_REV_DIGITAL: rev_next = din_reverse;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      relay1_reg  <= 1'b0;
      relay2_reg  <= 1'b0;
      setup2_reg  <= 1'b0;
      reverse_reg <= 1'b0;
    end
    else
    begin
      relay1_reg  <= (i_relay1_function == RELAY1_FUNC_CW11)
                     && cmd_bit(drive_command_word_reg, CMD_RELAY1);
      relay2_reg  <= (i_relay2_function == RELAY2_FUNC_CW12)
                     && cmd_bit(drive_command_word_reg, CMD_RELAY2);
      if (i_active_setup == SETUP_MULTI)
        setup2_reg <= cmd_bit(drive_command_word_reg, CMD_SETUP);
      else
        setup2_reg <= 1'b0;
      reverse_reg <= rev_next;
    end
  end

  // assemble the condition word
  always_comb
  begin
    condition_next                  = 16'h0000;
    condition_next[STS_CTRL_READY]  = i_controls_ready && !i_tripped;
    condition_next[STS_DRIVE_READY] = i_drive_ready;
    condition_next[STS_ENABLE]      = !coast_reg;
    condition_next[STS_TRIP]        = i_tripped;
    condition_next[STS_ERROR]       = i_error && !i_tripped;
    condition_next[STS_RESERVED]    = 1'b0;
    condition_next[STS_TRIPLOCK]    = i_trip_locked;
    condition_next[STS_WARNING]     = i_warning;
    condition_next[STS_AT_REF]      = i_at_reference;
    condition_next[STS_BUS_CTRL]    = !i_panel_off && !i_site_local;
    condition_next[STS_FREQ_OK]     = i_freq_in_limits;
    condition_next[STS_RUNNING]     = i_start_present || i_freq_nonzero;
    condition_next[STS_OVERTEMP]    = i_overtemp_pause;
    condition_next[STS_VOLTAGE]     = i_dc_voltage_bad;
    condition_next[STS_TORQUE]      = i_current_limit;
    condition_next[STS_TIMER]       = i_thermal_timer_over;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      condition_reg <= 16'h0000;
    else
      condition_reg <= condition_next;
  end

  // outputs straight from flip-flops
  assign o_preset_select        = preset_reg;
  assign o_dc_brake             = dc_brake_reg;
  assign o_coast                = coast_reg;
  assign o_quick_stop           = quick_stop_reg;
  assign o_freeze               = freeze_reg;
  assign o_speed_up             = speed_up_reg;
  assign o_slow_down            = slow_down_reg;
  assign o_ramp_stop            = ramp_stop_reg;
  assign o_start_enable         = start_enable_reg;
  assign o_trip_reset           = trip_reset_reg;
  assign o_jog                  = jog_reg;
  assign o_ramp_pair2           = ramp_pair2_reg;
  assign o_relay1               = relay1_reg;
  assign o_relay2               = relay2_reg;
  assign o_setup2               = setup2_reg;
  assign o_reverse              = reverse_reg;
  assign o_drive_condition_word = condition_reg;
endmodule

// File: shared/dcs_pkg.sv
// package for the drive command/condition word block
package dcs_pkg;
  localparam int DCS_WORD_W = 16;

  // command word bit positions
  localparam int CMD_REF_LSB = 0;
  localparam int CMD_REF_MSB = 1;
  localparam int CMD_DC_BRAKE_N = 2;
  localparam int CMD_COAST_N = 3;
  localparam int CMD_QSTOP_N = 4;
  localparam int CMD_HOLD_N = 5;
  localparam int CMD_RAMP_START = 6;
  localparam int CMD_RESET = 7;
  localparam int CMD_JOG = 8;
  localparam int CMD_RAMP_SEL = 9;
  localparam int CMD_VALID = 10;
  localparam int CMD_RELAY1 = 11;
  localparam int CMD_RELAY2 = 12;
  localparam int CMD_SETUP = 13;
  localparam int CMD_REVERSE = 15;

  // condition word bit positions
  localparam int STS_CTRL_READY = 0;
  localparam int STS_DRIVE_READY = 1;
  localparam int STS_ENABLE = 2;
  localparam int STS_TRIP = 3;
  localparam int STS_ERROR = 4;
  localparam int STS_RESERVED = 5;
  localparam int STS_TRIPLOCK = 6;
  localparam int STS_WARNING = 7;
  localparam int STS_AT_REF = 8;
  localparam int STS_BUS_CTRL = 9;
  localparam int STS_FREQ_OK = 10;
  localparam int STS_RUNNING = 11;
  localparam int STS_OVERTEMP = 12;
  localparam int STS_VOLTAGE = 13;
  localparam int STS_TORQUE = 14;
  localparam int STS_TIMER = 15;

  // reset value of the held command word: everything stopped and coasting
  localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;

  // option codes of the drive settings
  localparam logic [5:0] RELAY1_FUNC_CW11 = 6'h24; // option 36
  localparam logic [5:0] RELAY2_FUNC_CW12 = 6'h25; // option 37
  localparam logic [3:0] SETUP_MULTI = 4'h9;       // option 9

  // reversing source selection
  typedef enum logic [1:0] {
    DCS_REV_DIGITAL = 2'h0,
    DCS_REV_SERIAL  = 2'h1,
    DCS_REV_OR      = 2'h2,
    DCS_REV_AND     = 2'h3
  } dcs_rev_src_t;
endpackage

// File: src/dcs_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module dcs_sync
  import dcs_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // raw pin and clean level
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;

  // shift chain; first stage read only by the second
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // accept a bit change only when stages two and three agree
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      level_reg <= '0;
    else
      for (int b = 0; b < WIDTH; b++)
        if (stage2_reg[b] == stage3_reg[b])
          level_reg[b] <= stage2_reg[b];
  end

  assign o_level = level_reg;
endmodule

// File: dv/dcs_word_core_asserts.sv
// checker for the drive command word decoder
`timescale 1ns/1ps
module dcs_word_core_asserts
  import dcs_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // command and settings
  input  wire logic [15:0] i_command_word,
  input  wire logic        i_command_strobe,
  input  wire logic [5:0]  i_relay1_function,
  input  wire logic        i_tripped,
  input  wire logic        i_panel_off,
  input  wire logic        i_site_local,
  // decoded outputs and condition word
  input  wire logic [1:0]  o_preset_select,
  input  wire logic        o_dc_brake,
  input  wire logic        o_coast,
  input  wire logic        o_quick_stop,
  input  wire logic        o_freeze,
  input  wire logic        o_ramp_stop,
  input  wire logic        o_start_enable,
  input  wire logic        o_trip_reset,
  input  wire logic        o_jog,
  input  wire logic        o_ramp_pair2,
  input  wire logic        o_relay1,
  input  wire logic [15:0] o_drive_condition_word
);
  logic        acc;
  logic        acc_reg;
  logic        rst_reg;
  logic [15:0] held_reg;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // accepted word, mirrored held word
  assign acc = i_command_strobe && i_command_word[CMD_VALID];
  always_ff @(posedge i_clock)
  begin
    acc_reg <= acc && !i_reset;
    rst_reg <= i_reset;
    held_reg <= i_reset ? CMD_RESET_VALUE : (acc ? i_command_word : held_reg);
  end
  AST_PRESET: assert property (acc |-> ##2
    {o_ramp_pair2, o_jog, o_preset_select} == $past({i_command_word[9:8], i_command_word[1:0]}, 2))
    else $error("preset, jog or ramp pair wrong");
  AST_HOLD_WORD: assert property (!$past(acc_reg) |-> $stable({o_ramp_pair2, o_jog, o_preset_select}))
    else $error("outputs moved without a valid word");
  AST_TRIP_EDGE: assert property (o_trip_reset ==
    ($past(held_reg[CMD_RESET]) && !$past(held_reg[CMD_RESET], 2)))
    else $error("trip reset not on rising bit");
  AST_TRIP_PULSE: assert property (o_trip_reset |=> !o_trip_reset)
    else $error("trip reset longer than one cycle");
  AST_BRAKE: assert property (acc && !i_command_word[CMD_DC_BRAKE_N] |-> ##2 o_dc_brake)
    else $error("dc brake missing");
  AST_COAST: assert property (acc && !i_command_word[CMD_COAST_N] |-> ##2 o_coast && !o_start_enable)
    else $error("coast missing");
  AST_QSTOP: assert property (acc && i_command_word[5:4] == 2'h2 |-> ##2 o_quick_stop)
    else $error("quick stop missing");
  AST_FREEZE: assert property (acc && !i_command_word[CMD_HOLD_N] |-> ##2
    o_freeze && !o_quick_stop && !o_ramp_stop)
    else $error("freeze wrong");
  AST_RAMP_STOP: assert property (acc && i_command_word[6:5] == 2'h1 |-> ##2 o_ramp_stop && !o_start_enable)
    else $error("ramp stop missing");
  AST_RELAY1: assert property (!rst_reg |-> o_relay1 ==
    ($past(held_reg[CMD_RELAY1]) && $past(i_relay1_function) == RELAY1_FUNC_CW11))
    else $error("relay one wrong");
  AST_RESERVED: assert property (!o_drive_condition_word[STS_RESERVED])
    else $error("reserved status bit set");
  AST_TRIP_STS: assert property (!rst_reg |->
    {o_drive_condition_word[3], o_drive_condition_word[0] && $past(i_tripped)} == {$past(i_tripped), 1'b0})
    else $error("trip status wrong");
  AST_ENABLE: assert property (!rst_reg |-> o_drive_condition_word[STS_ENABLE] == !$past(o_coast))
    else $error("enable status wrong");
  AST_BUS: assert property (!rst_reg |->
    o_drive_condition_word[STS_BUS_CTRL] == !$past(i_panel_off || i_site_local))
    else $error("bus control status wrong");
  // main scenarios
  COV_TRIP: cover property (acc ##2 o_trip_reset);
  COV_FREEZE: cover property (o_freeze && o_dc_brake);
  COV_IGNORED: cover property (i_command_strobe && !i_command_word[CMD_VALID]);
endmodule
bind dcs_word_core dcs_word_core_asserts u_chk (.i_clock(i_clock), .i_reset(i_reset),
  .i_command_word(i_command_word), .i_command_strobe(i_command_strobe), .i_relay1_function(i_relay1_function),
  .i_tripped(i_tripped), .i_panel_off(i_panel_off), .i_site_local(i_site_local),
  .o_preset_select(o_preset_select), .o_dc_brake(o_dc_brake), .o_coast(o_coast), .o_quick_stop(o_quick_stop),
  .o_freeze(o_freeze), .o_ramp_stop(o_ramp_stop), .o_start_enable(o_start_enable), .o_trip_reset(o_trip_reset),
  .o_jog(o_jog), .o_ramp_pair2(o_ramp_pair2), .o_relay1(o_relay1), .o_drive_condition_word(o_drive_condition_word));

// File: dv/dcs_master_model.sv
// fieldbus master model sending command words
`timescale 1ns/1ps
module dcs_master_model
  import dcs_pkg::*;
(
  // clock
  input  wire logic   i_clock,
  // command word to the drive
  output logic [15:0] o_command_word,
  output logic        o_command_strobe
);
  // idle bus at start
  initial
  begin
    o_command_word = 16'h0000;
    o_command_strobe = 1'b0;
  end
  // one-cycle strobe, bus shows inverted data afterwards
  task automatic send(input logic [15:0] w, input logic params_only);
    @(posedge i_clock);
    #1;
    o_command_word = params_only ? (w & 16'hfbff) : w;
    o_command_strobe = 1'b1;
    @(posedge i_clock);
    #1;
    o_command_strobe = 1'b0;
    o_command_word = ~o_command_word;
  endtask
endmodule

// File: dv/testbench.sv
// self-checking bench for the command word decoder
`timescale 1ns/1ps
module testbench
  import dcs_pkg::*;
;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic [15:0] cw;
  logic        cs;
  logic [5:0]  f1 = 6'h24;
  logic [5:0]  f2 = 6'h25;
  logic [3:0]  su = 4'h9;
  logic [1:0]  rs = 2'h1;
  logic [4:0]  din = 5'h00;
  logic [15:0] st = 16'h0000;
  logic [15:0] dec;
  logic [15:0] sts;
  logic [15:0] e;
  logic        rev;
  int          n_errors = 0;
  int          tests_run = 0;
  int          trips = 0;
  // clock and trip pulse count
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) if (dec[10] === 1'b1) trips++;
  dcs_master_model master (.i_clock(i_clock), .o_command_word(cw), .o_command_strobe(cs));
  dcs_word_core dut (.i_clock(i_clock), .i_reset(i_reset), .i_command_word(cw), .i_command_strobe(cs),
    .i_relay1_function(f1), .i_relay2_function(f2), .i_active_setup(su), .i_reverse_source(rs),
    .i_din_reverse(din[4]), .i_din_coast(din[3]), .i_din_dc_brake(din[2]), .i_din_speed_up(din[1]),
    .i_din_slow_down(din[0]), .i_controls_ready(st[0]), .i_drive_ready(st[1]), .i_tripped(st[2]),
    .i_error(st[3]), .i_trip_locked(st[4]), .i_warning(st[5]), .i_at_reference(st[6]), .i_panel_off(st[7]),
    .i_site_local(st[8]), .i_freq_in_limits(st[9]), .i_start_present(st[10]), .i_freq_nonzero(st[11]),
    .i_overtemp_pause(st[12]), .i_dc_voltage_bad(st[13]), .i_current_limit(st[14]),
    .i_thermal_timer_over(st[15]), .o_preset_select(dec[1:0]), .o_dc_brake(dec[2]), .o_coast(dec[3]),
    .o_quick_stop(dec[4]), .o_freeze(dec[5]), .o_speed_up(dec[6]), .o_slow_down(dec[7]),
    .o_ramp_stop(dec[8]), .o_start_enable(dec[9]), .o_trip_reset(dec[10]), .o_jog(dec[11]),
    .o_ramp_pair2(dec[12]), .o_relay1(dec[13]), .o_relay2(dec[14]), .o_setup2(dec[15]), .o_reverse(rev),
    .o_drive_condition_word(sts));
  // compare and count
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    tests_run++;
    if (g !== x)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // valid word, then let outputs settle
  task automatic put(input logic [15:0] w);
    master.send(w, 1'b0);
    wt(3);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #50000;
    n_errors++;
    complete_run();
  end
  // test sequence
  initial
  begin
    wt(5);
    chk("reset sts", 16'h0000, sts);
    chk("reset dec", 16'h0108, dec);
    i_reset = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      put(16'(16'h0400 | i | (i << 8)));
      chk("preset", 16'(i | (i << 11)), dec & 16'h1803);
    end
    master.send(16'h0003, 1'b1);
    wt(3);
    chk("ignored", 16'h1803, dec & 16'h1803);
    $display("test preset done");
    put(16'h0480);
    put(16'h0480);
    master.send(16'h0400, 1'b0);
    put(16'h0480);
    chk("trips", 16'h0002, trips[15:0]);
    $display("test trip done");
    for (int b = 1; b < 7; b++)
    begin
      put(16'(16'h047c & ~(1 << b)));
      e = (b == 1) ? 16'h0000 : (b == 6) ? 16'h0100 : 16'(1 << b);
      chk("stops", e | ((b == 3 || b == 6) ? 16'h0000 : 16'h0200), dec & 16'h033c);
    end
    put(16'h040c);
    chk("frozen", 16'h0020, dec & 16'h03fc);
    din = 5'h07;
    wt(8);
    chk("frozen din", 16'h00e4, dec & 16'h03fc);
    put(16'h047c);
    chk("thawed", 16'h0204, dec & 16'h03fc);
    din = 5'h08;
    wt(8);
    chk("din coast", 16'h0008, dec & 16'h03fc);
    chk("enable sts", 16'h0000, sts & 16'h0004);
    din = 5'h00;
    $display("test stops done");
    put(16'hbc7c);
    chk("relays", 16'he000, dec & 16'he000);
    f1 = 6'h23;
    f2 = 6'h24;
    su = 4'h8;
    wt(3);
    chk("relays off", 16'h0000, dec & 16'he000);
    for (int p = 0; p < 2; p++)
    begin
      put(p ? 16'h847c : 16'h047c);
      for (int s = 0; s < 4; s++)
      begin
        rs = s[1:0];
        din[4] = !p;
        wt(8);
        e = (s == 0) ? !p : (s == 1) ? p : (s == 2) ? 1 : 0;
        chk("reverse", e, {15'h0000, rev});
      end
    end
    $display("test relay done");
    for (int i = 0; i < 18; i++)
    begin
      st = (i < 16) ? 16'(1 << i) : ((i == 16) ? 16'h000d : 16'hffff);
      wt(2);
      e = {st[15:12], st[10] | st[11], st[9], !st[7] && !st[8], st[6], st[5], st[4], 1'b0,
           st[3] && !st[2], st[2], 1'b1, st[1], st[0] && !st[2]};
      chk("status", e, sts);
    end
    $display("test status done");
    complete_run();
  end
endmodule
